//--- inc/sync_ctrl_pkg.sv
/*
  Constants, register offsets, field positions and carrier types of the SYSREF,
  trigger and NCO synchronisation block.
  Assumes a byte-wide register port with 9-bit register indices.
*/
package sync_ctrl_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [8:0] SYNC_CONTROL_ADDR  = 9'h1c0;
  localparam logic [8:0] TRIGGER_DELAY_ADDR = 9'h1c1;
  localparam logic [8:0] SYSREF_DELAY_ADDR  = 9'h1c2;
  localparam logic [8:0] TRIGGER_CTRL_ADDR  = 9'h1c3;
  localparam logic [8:0] DOWNCONVERTER_SYNC_CONTROL_ADDR = 9'h1c4;
  localparam logic [8:0] DDC_STATUS_ADDR    = 9'h1c5;

  // ********************************
  // reset values and field positions
  // ********************************
  localparam logic [7:0] SYNC_CONTROL_RESET  = 8'h18;
  localparam logic [7:0] TRIGGER_CTRL_RESET  = 8'h10;
  localparam logic [7:0] DOWNCONVERTER_SYNC_CONTROL_RESET = 8'h02;
  localparam logic [7:0] SYNC_CONTROL_WMASK  = 8'h0f;
  localparam logic [7:0] DDC_SYNC_WMASK      = 8'h13;
  localparam int BIT_RESYNC_SELECT   = 2;
  localparam int BIT_EDGE_DETECT     = 1;
  localparam int BIT_NCO_EVERY_PULSE = 3;
  localparam int BIT_SOFT_RESET      = 4;
  localparam int BIT_SYNC_ENABLE     = 1;
  localparam int BIT_ONE_SHOT        = 0;
  localparam int TRIG_EDGE_HI        = 7;
  localparam int TRIG_EDGE_LO        = 6;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_POS  = 2'h1;
  localparam logic [1:0] EDGE_NEG  = 2'h2;

  // clk_sys stands for fs/4; the fs/2 SYSREF delay runs two units per cycle
  localparam int DELAY_DEPTH = 256;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

endpackage : sync_ctrl_pkg

//--- logic/sync_ctrl.sv
/*
  SYSREF / trigger conditioning and down-converter NCO synchronisation.
  Assumes clk_sys is the fs/4 clock; sysref and trigger come from pins.
*/
// What this block does
// [R1] resync select 1 lets the SYSREF event resynchronise clocks, 0 never does.
// [R2] edge detect 1 turns a SYSREF rising edge into the event, 0 uses the level.
// [R3] the trigger is delayed by an 8-bit count of fs/4 cycles, zero meaning none.
// [R4] SYSREF is delayed by an 8-bit count of fs/2 cycles, reset to zero.
// [R5] trigger edge code 00 passes the level, 01 detects rise, 10 detects fall.
// [R6] soft reset bit 1 holds the down-converter in reset, 0 lets it run.
// [R7] releasing the soft reset restarts every NCO together.
// [R8] one-shot 0 syncs NCOs on every valid edge, 1 only on the next one.
// [R9] the source keeps the SYSREF period a multiple of the NCO period.
// [R10] after a one-shot sync software clears the enable before re-arming.
// [R11] without the sync enable only a soft reset release syncs the NCOs.
// [R12] every-pulse 0 resets NCOs only on a resync SYSREF, 1 on every pulse.
// [R13] a read-only flag shows the enable was cleared after a one-shot sync.
// [R14] delays act before edge detection; all actions use the delayed event.
`timescale 1ns/1ps

module sync_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire sync_ctrl_pkg::reg_req_type reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      sysref_pin,
  input  wire logic                      trigger_pin,
  output logic                           clock_resync,
  output logic                           nco_sync,
  output logic                           trigger_event,
  output logic                           downconverter_reset
);
  import sync_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]             sys_sync;
    logic [2:0]             trig_sync;
    logic                   sys_level;
    logic                   trig_level;
    logic [DELAY_DEPTH-1:0] sys_line;
    logic [DELAY_DEPTH-1:0] trig_line;
    logic                   sys_prev;
    logic                   trig_prev;
    logic [7:0]             sync_control;
    logic [7:0]             trigger_delay;
    logic [7:0]             sysref_delay;
    logic [7:0]             trigger_control;
    logic [7:0]             ddc_ctrl;
    logic                   one_shot_done;
    logic                   clear_flag;
    logic                   soft_prev;
    logic [7:0]             rdata;
    logic                   clock_resync;
    logic                   nco_sync;
    logic                   trigger_event;
    logic                   ddc_reset;
  } state_type;

  state_type st;
  state_type next_st;

  // delayed tap: index 0 is the synchronised level one cycle late
  function automatic logic tap(input logic [DELAY_DEPTH-1:0] line, input logic [7:0] n);
    tap = line[n];
  endfunction : tap

  // combinational views of the delayed pins; they hold no state of their own
  logic sys_d;
  logic trig_d;
  logic sys_evt;
  logic trig_evt;
  logic [7:0] sys_taps;

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_st = st;
    // three-stage synchronisers; stage 0 feeds only stage 1
    next_st.sys_sync  = {st.sys_sync[1:0], sysref_pin};
    next_st.trig_sync = {st.trig_sync[1:0], trigger_pin};
    if (st.sys_sync[1] == st.sys_sync[2]) next_st.sys_level = st.sys_sync[2];
    if (st.trig_sync[1] == st.trig_sync[2]) next_st.trig_level = st.trig_sync[2];
    next_st.sys_line  = {st.sys_line[DELAY_DEPTH-2:0], st.sys_level};
    next_st.trig_line = {st.trig_line[DELAY_DEPTH-2:0], st.trig_level};
    // two fs/2 units per clk_sys cycle; odd counts round up by one
    sys_taps = 8'((9'(st.sysref_delay) + 9'h1) >> 1);
    sys_d  = (st.sysref_delay == 8'h0) ? st.sys_level : tap(st.sys_line, sys_taps - 8'h1); // R4 R14
    trig_d = (st.trigger_delay == 8'h0) ? st.trig_level
                                          : tap(st.trig_line, st.trigger_delay - 8'h1); // R3 R14
    next_st.sys_prev  = sys_d;
    next_st.trig_prev = trig_d;
    // edge detection after the delay line
    sys_evt = st.sync_control[BIT_EDGE_DETECT] ? (sys_d & ~st.sys_prev) : sys_d; // R2 R14
    case (st.trigger_control[TRIG_EDGE_HI:TRIG_EDGE_LO]) // R5
      EDGE_NONE: trig_evt = trig_d;
      EDGE_POS:  trig_evt = trig_d & ~st.trig_prev;
      EDGE_NEG:  trig_evt = ~trig_d & st.trig_prev;
      default:   trig_evt = 1'b0;
    endcase
    next_st.trigger_event = trig_evt;
    next_st.clock_resync  = sys_evt & st.sync_control[BIT_RESYNC_SELECT]; // R1
    next_st.ddc_reset     = st.ddc_ctrl[BIT_SOFT_RESET]; // R6
    next_st.soft_prev     = st.ddc_ctrl[BIT_SOFT_RESET];
    next_st.nco_sync = 1'b0;
    // coherent restart of all NCOs on the falling edge of soft reset
    if (st.soft_prev && !st.ddc_ctrl[BIT_SOFT_RESET]) next_st.nco_sync = 1'b1; // R7
    if (sys_evt && st.ddc_ctrl[BIT_SYNC_ENABLE] && !st.one_shot_done && // R11
        (st.sync_control[BIT_NCO_EVERY_PULSE] || st.sync_control[BIT_RESYNC_SELECT])) begin // R12
      next_st.nco_sync = 1'b1;
      if (st.ddc_ctrl[BIT_ONE_SHOT]) next_st.one_shot_done = 1'b1; // R8
    end
    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        SYNC_CONTROL_ADDR:  next_st.sync_control = (reg_req.wdata & SYNC_CONTROL_WMASK)
                                                 | (SYNC_CONTROL_RESET & ~SYNC_CONTROL_WMASK);
        TRIGGER_DELAY_ADDR: next_st.trigger_delay = reg_req.wdata;
        SYSREF_DELAY_ADDR:  next_st.sysref_delay = reg_req.wdata;
        TRIGGER_CTRL_ADDR:  next_st.trigger_control = reg_req.wdata;
        DOWNCONVERTER_SYNC_CONTROL_ADDR: next_st.ddc_ctrl = reg_req.wdata & DDC_SYNC_WMASK;
        default: ;
      endcase
    end
    // clearing the enable after a one-shot re-arms and raises the flag
    if (!next_st.ddc_ctrl[BIT_SYNC_ENABLE] && st.one_shot_done) begin // R10 R13
      next_st.one_shot_done = 1'b0;
      next_st.clear_flag    = 1'b1;
    end
    if (next_st.ddc_ctrl[BIT_SYNC_ENABLE] && !st.ddc_ctrl[BIT_SYNC_ENABLE])
      next_st.clear_flag = 1'b0; // re-arming starts a new cycle
    // read data stands the cycle after the strobe only
    next_st.rdata = 8'h0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        SYNC_CONTROL_ADDR:  next_st.rdata = st.sync_control;
        TRIGGER_DELAY_ADDR: next_st.rdata = st.trigger_delay;
        SYSREF_DELAY_ADDR:  next_st.rdata = st.sysref_delay;
        TRIGGER_CTRL_ADDR:  next_st.rdata = st.trigger_control;
        DOWNCONVERTER_SYNC_CONTROL_ADDR: next_st.rdata = st.ddc_ctrl;
        DDC_STATUS_ADDR:    next_st.rdata = {7'h0, st.clear_flag}; // R13
        default:            next_st.rdata = 8'h0;
      endcase
    end
  end

  // ********************************
  // state register
  // ********************************
  // the whole state moves as one word, so fields never disagree by a cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.sync_control    <= SYNC_CONTROL_RESET;
      st.trigger_control <= TRIGGER_CTRL_RESET;
      st.ddc_ctrl        <= DOWNCONVERTER_SYNC_CONTROL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // every output is a field of the state register, so none of them glitches
  assign reg_rdata           = st.rdata;
  assign clock_resync        = st.clock_resync;
  assign nco_sync            = st.nco_sync;
  assign trigger_event       = st.trigger_event;
  assign downconverter_reset = st.ddc_reset;

  // ********************************
  // checks
  // ********************************
  // the soft reset bit reaches the pin two edges after its write
  property p_soft_reset;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == DOWNCONVERTER_SYNC_CONTROL_ADDR) |=> ##1
        (downconverter_reset == $past(reg_req.wdata[BIT_SOFT_RESET], 2));
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied"); // R6

  // dropping the soft reset restarts the nco one edge later
  property p_release;
    @(posedge clk_sys) disable iff (!rst_b)
      $fell(st.ddc_ctrl[BIT_SOFT_RESET]) |=> nco_sync;
  endproperty
  a_release: assert property (p_release) else $error("no nco restart on release"); // R7

  // with resync deselected the clocks are never disturbed
  property p_resync_off;
    @(posedge clk_sys) disable iff (!rst_b)
      !st.sync_control[BIT_RESYNC_SELECT] |=> !clock_resync;
  endproperty
  a_resync_off: assert property (p_resync_off) else $error("resync while disabled"); // R1

  // without the enable only a soft reset release may align the nco
  property p_no_enable;
    @(posedge clk_sys) disable iff (!rst_b)
      (!st.ddc_ctrl[BIT_SYNC_ENABLE] && !(st.soft_prev && !st.ddc_ctrl[BIT_SOFT_RESET]))
        |=> !nco_sync;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("nco sync without enable"); // R11

  // the cycle after a one-shot alignment is quiet
  property p_one_shot;
    @(posedge clk_sys) disable iff (!rst_b)
      (nco_sync && st.ddc_ctrl[BIT_ONE_SHOT] && st.one_shot_done && st.ddc_ctrl[BIT_SYNC_ENABLE]
       && !st.soft_prev) |=> !nco_sync || $past(st.soft_prev);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot synced twice"); // R8

  property p_every_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
      (!st.sync_control[BIT_NCO_EVERY_PULSE] && !st.sync_control[BIT_RESYNC_SELECT]
       && st.soft_prev == st.ddc_ctrl[BIT_SOFT_RESET]) |=> !nco_sync;
  endproperty
  a_every_pulse: assert property (p_every_pulse) else $error("nco reset w/o resync"); // R12

  property p_trig_none;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.trigger_control[TRIG_EDGE_HI:TRIG_EDGE_LO] == EDGE_NONE && st.trigger_delay == 8'h0)
        |=> trigger_event == $past(st.trig_level);
  endproperty
  a_trig_none: assert property (p_trig_none) else $error("trigger level not passed"); // R3 R5

  property p_sys_level;
    @(posedge clk_sys) disable iff (!rst_b)
      (!st.sync_control[BIT_EDGE_DETECT] && st.sync_control[BIT_RESYNC_SELECT]
       && st.sysref_delay == 8'h0) |=> clock_resync == $past(st.sys_level);
  endproperty
  a_sys_level: assert property (p_sys_level) else $error("sysref level not used"); // R2 R4

  property p_flag;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.one_shot_done && reg_req.wr && reg_req.addr == DOWNCONVERTER_SYNC_CONTROL_ADDR
       && !reg_req.wdata[BIT_SYNC_ENABLE]) |=> st.clear_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("clear flag not set"); // R13

  // an accepted trigger edge is a single-cycle strobe while the edge code stands still
  property p_trig_once;
    @(posedge clk_sys) disable iff (!rst_b)
      (trigger_event && st.trigger_control[TRIG_EDGE_HI:TRIG_EDGE_LO] != EDGE_NONE
       && $stable(st.trigger_control)) |=> !trigger_event;
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("trigger edge held too long"); // R5

  // the spare edge code must keep the trigger output quiet
  property p_trig_spare;
    @(posedge clk_sys) disable iff (!rst_b)
      (&st.trigger_control[TRIG_EDGE_HI:TRIG_EDGE_LO]) |=> !trigger_event;
  endproperty
  a_trig_spare: assert property (p_trig_spare) else $error("trigger on spare code"); // R5

  // in edge mode a SYSREF event cannot last past one cycle
  property p_sys_once;
    @(posedge clk_sys) disable iff (!rst_b)
      (clock_resync && st.sync_control[BIT_EDGE_DETECT] && $stable(st.sync_control))
        |=> !clock_resync;
  endproperty
  a_sys_once: assert property (p_sys_once) else $error("sysref edge held too long"); // R2

  // a selected resync must reach the clock resync output
  property p_resync_on;
    @(posedge clk_sys) disable iff (!rst_b)
      (sys_evt && st.sync_control[BIT_RESYNC_SELECT]) |=> clock_resync;
  endproperty
  a_resync_on: assert property (p_resync_on) else $error("selected resync lost"); // R1

  // every-pulse mode aligns the nco on each enabled event
  property p_every_sync;
    @(posedge clk_sys) disable iff (!rst_b)
      (sys_evt && st.sync_control[BIT_NCO_EVERY_PULSE] && st.ddc_ctrl[BIT_SYNC_ENABLE]
       && !st.one_shot_done) |=> nco_sync;
  endproperty
  a_every_sync: assert property (p_every_sync) else $error("every-pulse nco sync lost"); // R12

  // once the one-shot edge is used only a soft reset release may align again
  property p_one_shot_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.one_shot_done && !(st.soft_prev && !st.ddc_ctrl[BIT_SOFT_RESET])) |=> !nco_sync;
  endproperty
  a_one_shot_hold: assert property (p_one_shot_hold) else $error("spent one-shot synced"); // R8

  // setting the enable again starts a fresh cycle with the status flag low
  property p_flag_clear;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == DOWNCONVERTER_SYNC_CONTROL_ADDR && reg_req.wdata[BIT_SYNC_ENABLE]
       && !st.ddc_ctrl[BIT_SYNC_ENABLE]) |=> !st.clear_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("clear flag not reset"); // R13

  // a set soft reset bit keeps the down-converter held until it is rewritten
  property p_soft_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (st.ddc_ctrl[BIT_SOFT_RESET] && !(reg_req.wr && reg_req.addr == DOWNCONVERTER_SYNC_CONTROL_ADDR))
        |=> downconverter_reset ##1 downconverter_reset;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset dropped"); // R6

  // read data stand only in the cycle after a read strobe, zero elsewhere
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !reg_req.rd |=> reg_rdata == 8'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

endmodule : sync_ctrl

//--- tb/sysref_source.sv
/* behavioural clock and timing source for the sysref and trigger pins.
   assumes the bench calls pulse from its clk_sys process. */
`timescale 1ns/1ps
module sysref_source (
  input  wire logic clk_sys,
  output logic      sysref_pin,
  output logic      trigger_pin
);
  int cyc   = 0;
  int t_src = 0; // cycle of the last rising pin
  initial sysref_pin = 1'b0;
  initial trigger_pin = 1'b0;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end
  // one pulse of w cycles, then the pin rests low until the next call
  task automatic pulse(input bit trg, input int w);
    @(posedge clk_sys);
    if (trg) trigger_pin <= 1'b1;
    else sysref_pin <= 1'b1;
    t_src = cyc;
    repeat (w) @(posedge clk_sys);
    trigger_pin <= 1'b0;
    sysref_pin <= 1'b0;
    // gap of 8 keeps the pulse period a whole number of nco periods
    repeat (8) @(posedge clk_sys);
  endtask : pulse
endmodule : sysref_source

//--- tb/testbench.sv
/* self-checking bench of the sysref, trigger and nco sync block.
   assumes the design package and the sysref_source partner model. */
`timescale 1ns/1ps
module testbench;
  import sync_ctrl_pkg::*;
  logic        clk_sys, rst_b, sysref_pin, trigger_pin, rd_d = 1'b0;
  logic        clock_resync, nco_sync, trigger_event, downconverter_reset;
  logic        p_res = 1'b0, p_trg = 1'b0;
  logic [7:0]  reg_rdata, w, note_q[$];
  reg_req_type reg_req;
  int n_fail = 0, n_compared = 0, cyc = 0, t_out = 0;
  int n_res = 0, n_nco = 0, n_trg = 0, s_res, s_nco, s_trg, l0, d;

  sync_ctrl sync_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sysref_pin(sysref_pin), .trigger_pin(trigger_pin),
    .clock_resync(clock_resync), .nco_sync(nco_sync), .trigger_event(trigger_event),
    .downconverter_reset(downconverter_reset));
  sysref_source sysref_source_i (.clk_sys(clk_sys), .sysref_pin(sysref_pin),
    .trigger_pin(trigger_pin));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // **********
  // monitor: counts output cycles, stamps rises, checks read data
  // **********
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_res <= n_res + clock_resync;
    n_nco <= n_nco + nco_sync;
    n_trg <= n_trg + trigger_event;
    if ((clock_resync & !p_res) | (trigger_event & !p_trg)) t_out <= cyc;
    p_res <= clock_resync;
    p_trg <= trigger_event;
    rd_d <= reg_req.rd;
    if (rd_d === 1'b1) chk("reg_rdata", note_q.pop_front(), reg_rdata);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // one bus cycle; the next call or sett replaces it, so no signal is set twice
  task automatic acc(input logic [8:0] a, input logic [7:0] v, input bit r);
    if (r) note_q.push_back(v);
    reg_req <= '{addr: a, wdata: r ? 8'h00 : v, wr: !r, rd: r};
    @(posedge clk_sys);
  endtask : acc
  // drop the strobe and let n edges pass
  task automatic hold(input int n);
    reg_req <= '0;
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // as hold, then snapshot the output counts for a later difference
  task automatic sett(input int n);
    hold(n);
    s_res = n_res;
    s_nco = n_nco;
    s_trg = n_trg;
  endtask : sett
  task automatic meas(input bit trg, input int wd, output int l);
    sysref_source_i.pulse(trg, wd);
    repeat (50) @(posedge clk_sys);
    l = t_out - sysref_source_i.t_src;
  endtask : meas
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    void'($urandom(89782));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    // reset values, masks, read-only and unmapped places
    acc(SYNC_CONTROL_ADDR, 8'h18, 1);
    acc(TRIGGER_DELAY_ADDR, 8'h00, 1);
    acc(SYSREF_DELAY_ADDR, 8'h00, 1);
    acc(TRIGGER_CTRL_ADDR, 8'h10, 1);
    acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, 8'h02, 1);
    acc(DDC_STATUS_ADDR, 8'h00, 1);
    acc(9'h1c6, 8'h00, 1);
    w = 8'($urandom);
    acc(SYNC_CONTROL_ADDR, w, 0);
    acc(SYNC_CONTROL_ADDR, {4'h1, w[3:0]}, 1);
    acc(DDC_STATUS_ADDR, w, 0);
    acc(DDC_STATUS_ADDR, 8'h00, 1);
    // every trigger edge code on a 4-cycle pulse
    for (int c = 0; c < 4; c++) begin
      acc(TRIGGER_CTRL_ADDR, {2'(c), 6'h10}, 0);
      sett(4);
      sysref_source_i.pulse(1, 4);
      hold(12);
      chk("trig_cnt", c == 0 ? 4 : c == 3 ? 0 : 1, n_trg - s_trg);
    end
    // trigger delay on the delayed rising edge
    d = 1 + $urandom % 40;
    acc(TRIGGER_CTRL_ADDR, {EDGE_POS, 6'h10}, 0);
    sett(2);
    meas(1, 2, l0);
    acc(TRIGGER_DELAY_ADDR, 8'(d), 0);
    sett(2);
    meas(1, 2, s_trg);
    chk("trig_lat", l0 + d, s_trg);
    // sysref delay counted in half cycles, edge and level modes
    acc(SYNC_CONTROL_ADDR, 8'h06, 0);
    sett(2);
    meas(0, 3, l0);
    chk("resync_cnt", 1, n_res - s_res);
    d = 1 + $urandom % 60;
    acc(SYSREF_DELAY_ADDR, 8'(d), 0);
    sett(2);
    meas(0, 3, s_trg);
    chk("sysref_lat", l0 + (d + 1) / 2, s_trg);
    for (int m = 0; m < 5; m++) begin
      // level+resync, edge only, edge+every pulse, edge+resync, level alone
      acc(SYNC_CONTROL_ADDR, 8'(40'h00060a0204 >> (m * 8)), 0);
      sett(2);
      sysref_source_i.pulse(0, 4);
      hold(30);
      chk("resync_cnt", m == 0 ? 4 : m == 3 ? 1 : 0, n_res - s_res);
      chk("nco_cnt", m == 0 ? 4 : m == 1 || m == 4 ? 0 : 1, n_nco - s_nco);
    end
    // continuous, one-shot, disabled sync and soft reset
    acc(SYNC_CONTROL_ADDR, 8'h0a, 0);
    for (int m = 0; m < 3; m++) begin
      acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, m == 0 ? 8'h02 : m == 1 ? 8'h03 : 8'h01, 0);
      sett(2);
      sysref_source_i.pulse(0, 2);
      sysref_source_i.pulse(0, 2);
      hold(30);
      chk("nco_cnt", 2 - m, n_nco - s_nco);
    end
    acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, 8'h03, 0);
    sett(2);
    sysref_source_i.pulse(0, 2);
    // the delayed event must land before the enable is cleared
    hold(30);
    acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, 8'h01, 0);
    acc(DDC_STATUS_ADDR, 8'h01, 1);
    acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, 8'h12, 0);
    sett(3);
    chk("dc_reset", 1, downconverter_reset);
    acc(DOWNCONVERTER_SYNC_CONTROL_ADDR, 8'h02, 0);
    hold(10);
    chk("dc_reset", 0, downconverter_reset);
    chk("nco_cnt", 1, n_nco - s_nco);
    complete_run();
  end
endmodule : testbench
